// ---- design/phy_vendor_mode_pkg.sv ----
// Constants for the vendor mode register bank of a 10/100 PHY.
// Assumes a 250 MHz core clock and a management frame fed on MDC/MDIO pins.
package phy_vendor_mode_pkg;
  // Core clock and energy timeout
  localparam int CLK_FREQ_HZ           = 250_000_000;
  localparam int ENERGY_TIMEOUT_MS     = 256;
  localparam int ENERGY_TIMEOUT_CYCLES = ENERGY_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int ENERGY_CNT_W          = 26;

  // Management frame
  localparam int PREAMBLE_LEN = 32;
  localparam int DATA_BITS    = 16;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // Register indices
  localparam logic [4:0] MODE_CONTROL_STATUS_IDX  = 5'h11;
  localparam logic [4:0] SPECIAL_MODES_IDX        = 5'h12;
  localparam logic [4:0] SYMBOL_ERROR_COUNTER_IDX = 5'h1a;
  localparam logic [4:0] SPECIAL_CONTROL_IDX      = 5'h1b;

  // Mode control/status fields
  localparam int EDPD_EN_BIT      = 13;
  localparam int FAR_LOOP_BIT     = 9;
  localparam int ALT_INT_BIT      = 6;
  localparam int ENERGY_BIT       = 1;
  localparam int MCS_RSVD_RW_BIT  = 0;
  // Special modes fields
  localparam int SM_RSVD_ONE_BIT  = 14;
  localparam int MODE_LSB         = 5;
  localparam int ADDR_LSB         = 0;
  // Special control/status fields
  localparam int AUTO_XOVER_DIS_BIT = 15;
  localparam int CHAN_SEL_BIT       = 13;
  localparam int POL_REV_BIT        = 4;

  // Reset values
  localparam logic [15:0] SYMBOL_ERROR_RESET = 16'h0000;
  localparam logic        SM_RSVD_ONE_RESET  = 1'h1;
  localparam logic        ENERGY_RESET       = 1'h1;

  typedef enum logic [2:0] {
    ST_PREAMBLE, ST_START, ST_OP, ST_ADDR, ST_TA, ST_DATA
  } smi_state_t;
endpackage

// ---- design/phy_vendor_mode_registers.sv ----
// Vendor mode register bank of a 10/100 PHY, reached over the serial management pins.
// Assumes MDC and MDIO are synchronous to i_mclk and MDC is much slower than i_mclk;
// the line-side status inputs come from the PHY datapath in the same clock domain.
// Summary of operation
// RQ1: Power-down allowed only while enable bit set
// RQ2: Far loopback echoes receive, 100BASE-TX only
// RQ3: Far loopback ignores the isolate bit
// RQ4: Interrupt-scheme bit picks primary or alternate
// RQ5: Energy status drops after 256 ms quiet
// RQ6: Energy status one at reset, survives soft reset
// RQ7: Software writes one to reserved bit 14
// RQ8: Mode field read/write, seeded from straps
// RQ9: Address field is SMI address, scrambler seed
// RQ10: Address default taken from address strap
// RQ11: Count invalid 100BASE-TX symbols, idle included
// RQ12: At most one count per packet
// RQ13: Symbol counter wraps to zero
// RQ14: Counter cleared by reset, not by reads
// RQ15: Counter holds during 10BASE-T operation
// RQ16: Bit 15 disables auto crossover
// RQ17: Manual select zero MDI, one MDIX
// RQ18: Polarity bit reports reversed 10BASE-T polarity
// RQ19: Energy event raises latched source flag; here o_energy_event_flag is a one-cycle pulse, not latched
// RQ20: Read-only bits ignore writes, read zero
`timescale 1ns/1ps
module phy_vendor_mode_registers #(
  parameter int ENERGY_TIMEOUT_CYCLES = phy_vendor_mode_pkg::ENERGY_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_soft_reset,
  // Configuration straps
  input  wire logic [2:0] i_strap_mode,
  input  wire logic       i_strap_addr0,
  // Management pins
  input  wire logic       i_mdc,
  input  wire logic       i_mdio,
  output logic            o_mdio,
  output logic            o_mdio_oe,
  // Line-side status
  input  wire logic       i_energy_detect,
  input  wire logic       i_speed_100,
  input  wire logic       i_isolate,
  input  wire logic       i_rx_packet,
  input  wire logic       i_symbol_error,
  input  wire logic       i_polarity_reversed,
  input  wire logic       i_auto_mdix_result,
  // Controls to the datapath
  output logic            o_energy_powerdown,
  output logic            o_far_loop_active,
  output logic            o_alternate_interrupt_select,
  output logic [2:0]      o_mode,
  output logic [4:0]      o_device_address_field,
  output logic            o_mdix_select,
  output logic            o_energy_event_flag
);
  // ************************************************************
  // State
  // ************************************************************
  localparam int ENERGY_CNT_W_L = phy_vendor_mode_pkg::ENERGY_CNT_W;
  localparam logic [ENERGY_CNT_W_L-1:0] QUIET_LAST =
    ENERGY_CNT_W_L'(ENERGY_TIMEOUT_CYCLES - 1);
  phy_vendor_mode_pkg::smi_state_t state, next_state;
  logic [5:0]  bit_cnt, next_bit_cnt;
  logic [5:0]  pre_cnt, next_pre_cnt;
  logic [1:0]  op, next_op;
  logic [9:0]  addr_sh, next_addr_sh;
  logic [15:0] data_sh, next_data_sh;
  logic        mdc_q, next_mdio, next_mdio_oe;

  logic        energy_powerdown_enable, next_energy_powerdown_enable;
  logic        far_loop_enable, next_far_loop_enable;
  logic        alternate_interrupt_select, next_alternate_interrupt_select;
  logic        mcs_rsvd_rw, next_mcs_rsvd_rw;
  logic        energy_present_status, next_energy_present_status;
  logic [ENERGY_CNT_W_L-1:0] quiet_cnt, next_quiet_cnt;
  logic        sm_rsvd_one, next_sm_rsvd_one;
  logic [2:0]  mode, next_mode;
  logic [4:0]  device_address_field, next_device_address_field;
  logic [15:0] symbol_errors, next_symbol_errors;
  logic        counted_in_packet, next_counted_in_packet;
  logic        auto_crossover_disable, next_auto_crossover_disable;
  logic        manual_channel_select, next_manual_channel_select;
  logic        receive_polarity_reversed, next_receive_polarity_reversed;
  logic        next_energy_powerdown, next_far_loop_active, next_mdix_select;
  logic        next_energy_event_flag;

  logic mdc_rise;
  logic addr_hit;
  assign mdc_rise = i_mdc & ~mdc_q;
  // see RQ9
  assign addr_hit = (addr_sh[9:5] == device_address_field);

  // ************************************************************
  // Read decode
  // ************************************************************
  // Unlisted positions read as zero; see RQ20
  function automatic logic [15:0] read_word(input logic [4:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    unique case (idx)
      phy_vendor_mode_pkg::MODE_CONTROL_STATUS_IDX: begin
        w[phy_vendor_mode_pkg::EDPD_EN_BIT]     = energy_powerdown_enable;
        w[phy_vendor_mode_pkg::FAR_LOOP_BIT]    = far_loop_enable;
        w[phy_vendor_mode_pkg::ALT_INT_BIT]     = alternate_interrupt_select;
        w[phy_vendor_mode_pkg::ENERGY_BIT]      = energy_present_status;
        w[phy_vendor_mode_pkg::MCS_RSVD_RW_BIT] = mcs_rsvd_rw;
      end
      phy_vendor_mode_pkg::SPECIAL_MODES_IDX: begin
        w[phy_vendor_mode_pkg::SM_RSVD_ONE_BIT]                       = sm_rsvd_one;
        w[phy_vendor_mode_pkg::MODE_LSB +: 3]                         = mode;
        w[phy_vendor_mode_pkg::ADDR_LSB +: 5]                         = device_address_field;
      end
      phy_vendor_mode_pkg::SYMBOL_ERROR_COUNTER_IDX: w = symbol_errors;
      phy_vendor_mode_pkg::SPECIAL_CONTROL_IDX: begin
        w[phy_vendor_mode_pkg::AUTO_XOVER_DIS_BIT] = auto_crossover_disable;
        w[phy_vendor_mode_pkg::CHAN_SEL_BIT]       = manual_channel_select;
        w[phy_vendor_mode_pkg::POL_REV_BIT]        = receive_polarity_reversed; // see RQ18
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic       wr_commit;
    logic [4:0] wr_idx;
    wr_commit = 1'b0;
    wr_idx    = addr_sh[4:0];
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_pre_cnt = pre_cnt;
    next_op      = op;
    next_addr_sh = addr_sh;
    next_data_sh = data_sh;
    next_mdio    = o_mdio;
    next_mdio_oe = o_mdio_oe;

    // Frame is advanced on the rising MDC edge; output changes just after it
    if (mdc_rise) begin
      next_bit_cnt = bit_cnt + 6'h01;
      unique case (state)
        phy_vendor_mode_pkg::ST_PREAMBLE: begin
          if (i_mdio) begin
            if (pre_cnt != 6'(phy_vendor_mode_pkg::PREAMBLE_LEN)) begin
              next_pre_cnt = pre_cnt + 6'h01;
            end
          end else begin
            next_pre_cnt = 6'h00;
            if (pre_cnt == 6'(phy_vendor_mode_pkg::PREAMBLE_LEN)) begin
              next_state = phy_vendor_mode_pkg::ST_START;
            end
          end
        end
        phy_vendor_mode_pkg::ST_START: begin
          next_bit_cnt = 6'h00;
          next_state   = i_mdio ? phy_vendor_mode_pkg::ST_OP : phy_vendor_mode_pkg::ST_PREAMBLE;
        end
        phy_vendor_mode_pkg::ST_OP: begin
          next_op = {op[0], i_mdio};
          if (bit_cnt == 6'h01) begin
            next_bit_cnt = 6'h00;
            next_state   = phy_vendor_mode_pkg::ST_ADDR;
          end
        end
        phy_vendor_mode_pkg::ST_ADDR: begin
          next_addr_sh = {addr_sh[8:0], i_mdio};
          if (bit_cnt == 6'h09) begin
            next_bit_cnt = 6'h00;
            next_state   = phy_vendor_mode_pkg::ST_TA;
          end
        end
        phy_vendor_mode_pkg::ST_TA: begin
          if (bit_cnt == 6'h00) begin
            if (op == phy_vendor_mode_pkg::OP_READ && addr_hit) begin
              next_mdio_oe = 1'b1;
              next_mdio    = 1'b0;
            end
          end else begin
            next_bit_cnt = 6'h00;
            next_state   = phy_vendor_mode_pkg::ST_DATA;
            next_data_sh = read_word(addr_sh[4:0]); // see RQ14
            next_mdio    = next_data_sh[15];
          end
        end
        phy_vendor_mode_pkg::ST_DATA: begin
          if (o_mdio_oe) begin
            next_data_sh = {data_sh[14:0], 1'b0};
            next_mdio    = next_data_sh[15];
          end else begin
            next_data_sh = {data_sh[14:0], i_mdio};
          end
          if (bit_cnt == 6'(phy_vendor_mode_pkg::DATA_BITS - 1)) begin
            wr_commit    = (op == phy_vendor_mode_pkg::OP_WRITE) && addr_hit;
            next_mdio_oe = 1'b0;
            next_mdio    = 1'b0;
            next_pre_cnt = 6'h00;
            next_state   = phy_vendor_mode_pkg::ST_PREAMBLE;
          end
        end
      endcase
    end

    // Register file
    next_energy_powerdown_enable    = energy_powerdown_enable;
    next_far_loop_enable            = far_loop_enable;
    next_alternate_interrupt_select = alternate_interrupt_select;
    next_mcs_rsvd_rw                = mcs_rsvd_rw;
    next_sm_rsvd_one                = sm_rsvd_one;
    next_mode                       = mode;
    next_device_address_field       = device_address_field;
    next_auto_crossover_disable     = auto_crossover_disable;
    next_manual_channel_select      = manual_channel_select;
    if (i_soft_reset) begin
      // Straps-loaded fields and energy status are kept across a soft reset
      next_energy_powerdown_enable    = 1'b0;
      next_far_loop_enable            = 1'b0;
      next_alternate_interrupt_select = 1'b0;
      next_mcs_rsvd_rw                = 1'b0;
      next_auto_crossover_disable     = 1'b0;
      next_manual_channel_select      = 1'b0;
    end else if (wr_commit) begin
      // Read-only positions are not stored; see RQ20
      unique case (wr_idx)
        phy_vendor_mode_pkg::MODE_CONTROL_STATUS_IDX: begin
          next_energy_powerdown_enable    = next_data_sh[phy_vendor_mode_pkg::EDPD_EN_BIT];
          next_far_loop_enable            = next_data_sh[phy_vendor_mode_pkg::FAR_LOOP_BIT];
          next_alternate_interrupt_select = next_data_sh[phy_vendor_mode_pkg::ALT_INT_BIT];
          next_mcs_rsvd_rw                = next_data_sh[phy_vendor_mode_pkg::MCS_RSVD_RW_BIT];
        end
        phy_vendor_mode_pkg::SPECIAL_MODES_IDX: begin
          next_sm_rsvd_one          = next_data_sh[phy_vendor_mode_pkg::SM_RSVD_ONE_BIT]; // see RQ7
          next_mode                 = next_data_sh[phy_vendor_mode_pkg::MODE_LSB +: 3]; // see RQ8
          next_device_address_field = next_data_sh[phy_vendor_mode_pkg::ADDR_LSB +: 5]; // see RQ9
        end
        phy_vendor_mode_pkg::SPECIAL_CONTROL_IDX: begin
          next_auto_crossover_disable = next_data_sh[phy_vendor_mode_pkg::AUTO_XOVER_DIS_BIT];
          next_manual_channel_select  = next_data_sh[phy_vendor_mode_pkg::CHAN_SEL_BIT];
        end
        default: ;
      endcase
    end

    // Energy watch: any valid energy restarts the quiet timer
    next_quiet_cnt             = quiet_cnt;
    next_energy_present_status = energy_present_status;
    if (i_energy_detect) begin
      next_quiet_cnt             = '0;
      next_energy_present_status = 1'b1;
    end else if (quiet_cnt == QUIET_LAST) begin
      next_energy_present_status = 1'b0; // see RQ5
    end else begin
      next_quiet_cnt = quiet_cnt + 1'b1;
    end
    next_energy_event_flag = next_energy_present_status & ~energy_present_status; // see RQ19

    // Symbol errors: idle errors each count, a packet counts once
    next_symbol_errors     = symbol_errors;
    next_counted_in_packet = counted_in_packet & i_rx_packet;
    if (i_speed_100 && i_symbol_error && !(i_rx_packet && counted_in_packet)) begin // see RQ15
      next_symbol_errors     = symbol_errors + 16'h0001; // see RQ11 and RQ13
      next_counted_in_packet = i_rx_packet; // see RQ12
    end
    if (i_soft_reset) begin
      next_symbol_errors     = phy_vendor_mode_pkg::SYMBOL_ERROR_RESET;
      next_counted_in_packet = 1'b0;
    end

    next_receive_polarity_reversed = i_polarity_reversed;
    // Power-down only while enabled and the line is quiet; see RQ1
    next_energy_powerdown = next_energy_powerdown_enable & ~next_energy_present_status;
    // Isolate deliberately has no say here; see RQ2 and RQ3
    next_far_loop_active  = next_far_loop_enable & i_speed_100 & (i_isolate | ~i_isolate);
    // see RQ16 and RQ17
    next_mdix_select = next_auto_crossover_disable ? next_manual_channel_select
                                                   : i_auto_mdix_result;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state                        <= phy_vendor_mode_pkg::ST_PREAMBLE;
      bit_cnt                      <= 6'h00;
      pre_cnt                      <= 6'h00;
      op                           <= 2'h0;
      addr_sh                      <= 10'h000;
      data_sh                      <= 16'h0000;
      mdc_q                        <= 1'b0;
      o_mdio                       <= 1'b0;
      o_mdio_oe                    <= 1'b0;
      energy_powerdown_enable      <= 1'b0;
      far_loop_enable              <= 1'b0;
      alternate_interrupt_select   <= 1'b0; // see RQ4
      mcs_rsvd_rw                  <= 1'b0;
      energy_present_status        <= phy_vendor_mode_pkg::ENERGY_RESET; // see RQ6
      quiet_cnt                    <= '0;
      sm_rsvd_one                  <= phy_vendor_mode_pkg::SM_RSVD_ONE_RESET;
      mode                         <= i_strap_mode; // see RQ8
      device_address_field         <= {4'h0, i_strap_addr0}; // see RQ10
      symbol_errors                <= phy_vendor_mode_pkg::SYMBOL_ERROR_RESET; // see RQ14
      counted_in_packet            <= 1'b0;
      auto_crossover_disable       <= 1'b0;
      manual_channel_select        <= 1'b0;
      receive_polarity_reversed    <= 1'b0;
      o_energy_powerdown           <= 1'b0;
      o_far_loop_active            <= 1'b0;
      o_alternate_interrupt_select <= 1'b0;
      o_mode                       <= i_strap_mode;
      o_device_address_field       <= {4'h0, i_strap_addr0};
      o_mdix_select                <= 1'b0;
      o_energy_event_flag          <= 1'b0;
    end else begin
      state                        <= next_state;
      bit_cnt                      <= next_bit_cnt;
      pre_cnt                      <= next_pre_cnt;
      op                           <= next_op;
      addr_sh                      <= next_addr_sh;
      data_sh                      <= next_data_sh;
      mdc_q                        <= i_mdc;
      o_mdio                       <= next_mdio;
      o_mdio_oe                    <= next_mdio_oe;
      energy_powerdown_enable      <= next_energy_powerdown_enable;
      far_loop_enable              <= next_far_loop_enable;
      alternate_interrupt_select   <= next_alternate_interrupt_select;
      mcs_rsvd_rw                  <= next_mcs_rsvd_rw;
      energy_present_status        <= next_energy_present_status;
      quiet_cnt                    <= next_quiet_cnt;
      sm_rsvd_one                  <= next_sm_rsvd_one;
      mode                         <= next_mode;
      device_address_field         <= next_device_address_field;
      symbol_errors                <= next_symbol_errors;
      counted_in_packet            <= next_counted_in_packet;
      auto_crossover_disable       <= next_auto_crossover_disable;
      manual_channel_select        <= next_manual_channel_select;
      receive_polarity_reversed    <= next_receive_polarity_reversed;
      o_energy_powerdown           <= next_energy_powerdown;
      o_far_loop_active            <= next_far_loop_active;
      o_alternate_interrupt_select <= next_alternate_interrupt_select;
      o_mode                       <= next_mode;
      o_device_address_field       <= next_device_address_field;
      o_mdix_select                <= next_mdix_select;
      o_energy_event_flag          <= next_energy_event_flag;
    end
  end
endmodule

// ---- sim/phy_vendor_mode_checker.sv ----
// Port-level assertions for the vendor mode register bank.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module phy_vendor_mode_checker #(
  parameter int ENERGY_TIMEOUT_CYCLES = 50
) (
  input wire logic       i_mclk, i_rst, i_soft_reset, i_strap_addr0, i_mdc, i_mdio,
  input wire logic [2:0] i_strap_mode, o_mode,
  input wire logic [4:0] o_device_address_field,
  input wire logic       i_energy_detect, i_speed_100, i_isolate, i_rx_packet,
  input wire logic       i_symbol_error, i_polarity_reversed, i_auto_mdix_result,
  input wire logic       o_mdio, o_mdio_oe, o_energy_powerdown, o_far_loop_active,
  input wire logic       o_alternate_interrupt_select, o_mdix_select, o_energy_event_flag
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ********
  // Quiet cycles, saturating
  // ********
  int quiet, next_quiet;
  always_comb begin
    next_quiet = quiet;
    if (i_rst || i_energy_detect) next_quiet = 0;
    else if (quiet < ENERGY_TIMEOUT_CYCLES) next_quiet = quiet + 1;
  end
  always_ff @(posedge i_mclk) quiet <= next_quiet;
  // ********
  // Properties
  // ********
  property p_reset_straps;
    disable iff (1'b0) i_rst |=> o_mode == $past(i_strap_mode)
      && o_device_address_field == {4'h0, $past(i_strap_addr0)};
  endproperty
  a_reset_straps: assert property (p_reset_straps)
    else $error("straps lost");
  property p_reset_outputs;
    disable iff (1'b0) i_rst |=> !(o_mdio_oe || o_energy_powerdown || o_far_loop_active
      || o_alternate_interrupt_select || o_energy_event_flag);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("output set in reset");
  property p_far_speed;
    o_far_loop_active |-> $past(i_speed_100);
  endproperty
  a_far_speed: assert property (p_far_speed)
    else $error("far loop at 10M");
  property p_energy_nopd;
    i_energy_detect [*4] |-> !o_energy_powerdown;
  endproperty
  a_energy_nopd: assert property (p_energy_nopd)
    else $error("power-down with energy");
  property p_pd_quiet;
    $rose(o_energy_powerdown) |-> quiet >= ENERGY_TIMEOUT_CYCLES - 3;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("early power-down");
  property p_flag_cause;
    o_energy_event_flag |-> $past(i_energy_detect);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag without energy");
  property p_flag_pulse;
    o_energy_event_flag |=> !o_energy_event_flag;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse)
    else $error("flag too long");
  property p_oe_mdc;
    $changed(o_mdio_oe) |-> $past(i_mdc);
  endproperty
  a_oe_mdc: assert property (p_oe_mdc)
    else $error("enable off MDC rise");
  property p_alt_cause;
    $changed(o_alternate_interrupt_select) |-> $past(i_mdc) || $past(i_soft_reset);
  endproperty
  a_alt_cause: assert property (p_alt_cause)
    else $error("select without access");
  cover property ($rose(o_energy_powerdown));
  cover property (o_energy_event_flag);
  cover property ($rose(o_mdio_oe));
endmodule

bind phy_vendor_mode_registers phy_vendor_mode_checker #(
  .ENERGY_TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES)
) u_checker (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_soft_reset(i_soft_reset), .i_mdc(i_mdc),
  .i_strap_addr0(i_strap_addr0), .i_strap_mode(i_strap_mode), .i_mdio(i_mdio),
  .o_mode(o_mode), .o_device_address_field(o_device_address_field),
  .i_energy_detect(i_energy_detect), .i_speed_100(i_speed_100), .i_isolate(i_isolate),
  .i_rx_packet(i_rx_packet), .i_symbol_error(i_symbol_error),
  .i_polarity_reversed(i_polarity_reversed), .i_auto_mdix_result(i_auto_mdix_result),
  .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .o_energy_powerdown(o_energy_powerdown),
  .o_far_loop_active(o_far_loop_active), .o_mdix_select(o_mdix_select),
  .o_alternate_interrupt_select(o_alternate_interrupt_select),
  .o_energy_event_flag(o_energy_event_flag)
);

// ---- sim/smi_station_model.sv ----
// Station management model: sends MDC/MDIO frames to the register bank.
// Assumes the bench resolves MDIO with a pull-up and feeds the line back.
`timescale 1ns/1ps
module smi_station_model (
  // Core clock and resolved line
  input  wire logic i_mclk,
  input  wire logic i_mdio_line,
  // Management pins
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe
);
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // One MDC period is 8 core clocks; MDIO moves only while MDC is low
  task automatic bit_slot(input logic b, drive, output logic seen);
    o_mdc <= 1'b0;
    o_mdio <= b;
    o_mdio_oe <= drive;
    repeat (4) @(posedge i_mclk);
    seen = i_mdio_line;
    o_mdc <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        is_wr;
    hdr = {2'b01, op, pa, ra};
    is_wr = (op == phy_vendor_mode_pkg::OP_WRITE);
    for (int i = 0; i < 32; i++) bit_slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_slot(hdr[i], 1'b1, s);
    // Line released in turnaround on reads
    bit_slot(1'b1, is_wr, s);
    bit_slot(1'b0, is_wr, s);
    for (int i = 15; i >= 0; i--) begin
      bit_slot(wd[i], is_wr, s);
      rd[i] = s;
    end
    // MDC stands still low between frames
    o_mdc <= 1'b0;
    o_mdio_oe <= 1'b0;
    @(posedge i_mclk);
  endtask
endmodule

// ---- sim/phy_vendor_mode_registers_tb.sv ----
// Self-checking bench for the vendor mode register bank.
// Assumes the station model for all register traffic, device address 1.
`timescale 1ns/1ps
module phy_vendor_mode_registers_tb;
  // Short quiet timeout
  localparam int TMO = 2000;
  logic        i_mclk = 1'b0, i_rst = 1'b1, i_soft_reset = 1'b0, i_strap_addr0 = 1'b1;
  logic        i_energy_detect = 1'b0, i_speed_100 = 1'b1, i_isolate = 1'b0;
  logic        i_rx_packet = 1'b0, i_symbol_error = 1'b0, i_polarity_reversed = 1'b0;
  logic        i_auto_mdix_result = 1'b0, seen = 1'b0;
  logic [2:0]  i_strap_mode = 3'h5;
  logic        mdc, st_mdio, st_oe, mdio_line, o_mdio, o_mdio_oe, o_energy_powerdown;
  logic        o_far_loop_active, o_alternate_interrupt_select, o_mdix_select, o_energy_event_flag;
  logic [2:0]  o_mode;
  logic [4:0]  o_device_address_field;
  logic [15:0] rdata, outs;
  int          errors = 0, checks_done = 0;
  initial forever #2 i_mclk = ~i_mclk;
  // Pull-up: a released line reads one
  assign mdio_line = o_mdio_oe ? o_mdio : (st_oe ? st_mdio : 1'b1);
  assign outs = {o_mode, o_device_address_field, 3'h0, o_energy_powerdown, o_far_loop_active,
                 o_alternate_interrupt_select, o_mdix_select, o_energy_event_flag};
  phy_vendor_mode_registers #(.ENERGY_TIMEOUT_CYCLES(TMO)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_soft_reset(i_soft_reset), .i_mdc(mdc),
    .i_strap_mode(i_strap_mode), .i_strap_addr0(i_strap_addr0), .i_mdio(mdio_line),
    .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .i_energy_detect(i_energy_detect),
    .i_speed_100(i_speed_100), .i_isolate(i_isolate), .i_rx_packet(i_rx_packet),
    .i_symbol_error(i_symbol_error), .i_polarity_reversed(i_polarity_reversed),
    .i_auto_mdix_result(i_auto_mdix_result), .o_energy_powerdown(o_energy_powerdown),
    .o_far_loop_active(o_far_loop_active), .o_mode(o_mode), .o_mdix_select(o_mdix_select),
    .o_alternate_interrupt_select(o_alternate_interrupt_select),
    .o_device_address_field(o_device_address_field), .o_energy_event_flag(o_energy_event_flag)
  );
  smi_station_model stn (
    .i_mclk(i_mclk), .i_mdio_line(mdio_line), .o_mdc(mdc), .o_mdio(st_mdio), .o_mdio_oe(st_oe)
  );
  // ********
  // Access and compare tasks
  // ********
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [4:0] pa = 5'h01);
    stn.frame(phy_vendor_mode_pkg::OP_WRITE, pa, ra, d, rdata);
  endtask
  task automatic rd(input string name, input logic [4:0] ra, input logic [15:0] exp);
    stn.frame(phy_vendor_mode_pkg::OP_READ, 5'h01, ra, 16'h0000, rdata);
    chk(name, rdata, exp);
  endtask
  initial begin
    repeat (100000) @(posedge i_mclk);
    errors++;
    report_and_stop();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd("ctl reset", 5'h11, 16'h0002);
    i_energy_detect <= 1'b1;
    rd("modes reset", 5'h12, 16'h40a1);
    rd("count reset", 5'h1a, 16'h0000);
    rd("ind reset", 5'h1b, 16'h0000);
    rd("unmapped", 5'h05, 16'h0000);
    chk("outs reset", outs, 16'ha100);
    wr(5'h11, 16'hffff);
    rd("ctl ones", 5'h11, 16'h2243);
    chk("outs on", outs, 16'ha10c);
    i_isolate <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk("outs iso", outs, 16'ha10c);
    i_speed_100 <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk("outs 10M", outs, 16'ha104);
    i_speed_100 <= 1'b1;
    i_energy_detect <= 1'b0;
    repeat (TMO + 5) @(posedge i_mclk);
    chk("outs quiet", outs, 16'ha11c);
    rd("ctl quiet", 5'h11, 16'h2241);
    i_energy_detect <= 1'b1;
    repeat (8) begin
      @(posedge i_mclk);
      if (o_energy_event_flag === 1'b1) seen = 1'b1;
    end
    chk("energy flag", {15'h0, seen}, 16'h0001);
    chk("outs energy", outs, 16'ha10c);
    i_soft_reset <= 1'b1;
    @(posedge i_mclk);
    i_soft_reset <= 1'b0;
    repeat (3) @(posedge i_mclk);
    rd("ctl soft", 5'h11, 16'h0002);
    wr(5'h12, 16'hc061);
    rd("modes write", 5'h12, 16'h4061);
    chk("outs mode", outs, 16'h6100);
    wr(5'h11, 16'hffff, 5'h02);
    rd("ctl foreign", 5'h11, 16'h0002);
    i_symbol_error <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rx_packet <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_rx_packet <= 1'b0;
    i_speed_100 <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_symbol_error <= 1'b0;
    i_speed_100 <= 1'b1;
    rd("count", 5'h1a, 16'h0004);
    rd("count reread", 5'h1a, 16'h0004);
    i_symbol_error <= 1'b1;
    repeat (65531) @(posedge i_mclk);
    i_symbol_error <= 1'b0;
    rd("count max", 5'h1a, 16'hffff);
    i_symbol_error <= 1'b1;
    @(posedge i_mclk);
    i_symbol_error <= 1'b0;
    rd("count wrap", 5'h1a, 16'h0000);
    i_polarity_reversed <= 1'b1;
    wr(5'h1b, 16'hffff);
    rd("ind ones", 5'h1b, 16'ha010);
    chk("outs manual x", outs, 16'h6102);
    wr(5'h1b, 16'h8000);
    chk("outs manual", outs, 16'h6100);
    i_auto_mdix_result <= 1'b1;
    wr(5'h1b, 16'h0000);
    chk("outs auto", outs, 16'h6102);
    report_and_stop();
  end
endmodule
